// ===== pkg/fifo_pkg.sv
// Shared constants for the dual-ended flag and retransmit FIFO
package fifo_pkg;
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned ADDR_W  = 15;
  localparam int unsigned DEPTH   = 32768;
  localparam int unsigned CNT_W   = 17;
  localparam int unsigned OFS_W   = 15;
  localparam int unsigned OFS_MSB = 14;
  localparam int unsigned LDC_W   = 5;
  localparam int unsigned RTC_W   = 5;

  // Flag depths in each timing mode
  localparam logic [CNT_W-1:0] DEPTH_STD  = 17'h08000;
  localparam logic [CNT_W-1:0] DEPTH_FALL = 17'h08001;
  localparam logic [CNT_W-1:0] WR_LIMIT_STD  = 17'h07FFE;
  localparam logic [CNT_W-1:0] WR_LIMIT_FALL = 17'h07FFF;

  // Offset defaults chosen by the load-select strap at reset
  localparam logic [OFS_W-1:0] OFS_DEF_LO = 15'h007F;
  localparam logic [OFS_W-1:0] OFS_DEF_HI = 15'h03FF;
  localparam logic [LDC_W-1:0] LOAD_BITS  = 5'h1E;

  // Retransmit setup time
  localparam int unsigned CLK_NS   = 5;
  localparam int unsigned RETX_NS  = 60;
  localparam int unsigned RETX_CYC = (RETX_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [RTC_W-1:0] RETX_LOAD = RTC_W'(RETX_CYC);
endpackage

// ===== pkg/fifo_link_if.sv
// Link between the FIFO device and its writing and reading party
`timescale 1ns/10ps
`default_nettype none
interface fifo_link_if;
  import fifo_pkg::*;
  logic              writeEnN;
  logic [DATA_W-1:0] dataIn;
  logic              readEnN;
  logic [DATA_W-1:0] dataOut;
  logic              retransmitN;
  logic              fallThroughMode;
  logic              offsetLoadSelectN;
  logic              serialEnN;
  logic              serialIn;
  logic              emptyFlagN;
  logic              fullFlagN;
  logic              outputReadyN;
  logic              inputReadyN;
  logic              almostEmptyFlagN;
  logic              almostFullFlagN;

  modport dev (
    input  writeEnN, dataIn, readEnN, retransmitN, fallThroughMode,
           offsetLoadSelectN, serialEnN, serialIn,
    output dataOut, emptyFlagN, fullFlagN, outputReadyN, inputReadyN,
           almostEmptyFlagN, almostFullFlagN
  );
  modport peer (
    output writeEnN, dataIn, readEnN, retransmitN, fallThroughMode,
           offsetLoadSelectN, serialEnN, serialIn,
    input  dataOut, emptyFlagN, fullFlagN, outputReadyN, inputReadyN,
           almostEmptyFlagN, almostFullFlagN
  );
endinterface
`default_nettype wire

// ===== src/fifo_device.sv
// FIFO device end: storage, flags, retransmit and offset loading
`timescale 1ns/10ps
`default_nettype none
module fifo_device
  import fifo_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  fifo_link_if.dev  link
);

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic              mode_r;
  logic [ADDR_W-1:0] wrPtr_r;
  logic [ADDR_W-1:0] rdPtr_r;
  logic [CNT_W-1:0]  memCnt_r;
  logic [CNT_W-1:0]  memCnt_nxt;
  logic              outValid_r;
  logic              memAvail_r;
  logic [DATA_W-1:0] dataOut_r;
  logic [RTC_W-1:0]  retxCnt_r;
  logic [OFS_W-1:0]  aeOfs_r;
  logic [OFS_W-1:0]  afOfs_r;
  logic [LDC_W-1:0]  loadCnt_r;
  logic              emptyFlagN_r;
  logic              fullFlagN_r;
  logic              inputReadyN_r;
  logic              almostEmptyN_r;
  logic              almostFullN_r;

  logic              busy;
  logic              retxStart;
  logic              wrDo;
  logic              rdDo;
  logic              outTake;
  logic              fetch;
  logic              pop;
  logic [CNT_W-1:0]  total;
  logic [CNT_W-1:0]  depthMax;
  logic [CNT_W-1:0]  aeThresh;
  logic [CNT_W-1:0]  afThresh;

  // ---------------------------------------------------------------
  // Transfer decisions
  // ---------------------------------------------------------------
  assign busy      = (retxCnt_r != '0);
  assign retxStart = !link.retransmitN && !busy;
  // Flag gates the writer; count guard covers the flag's one-cycle lag
  assign wrDo      = !link.writeEnN && (memCnt_r != DEPTH_STD) &&
                     (mode_r ? !inputReadyN_r : fullFlagN_r);
  // Count guard covers the cycle before the registered flag falls
  assign rdDo      = !mode_r && !link.readEnN && emptyFlagN_r &&
                     (memCnt_r != '0) && !busy;
  assign outTake   = mode_r && !link.readEnN && outValid_r;
  assign fetch     = mode_r && memAvail_r && (memCnt_r != '0) && !busy &&
                     (!outValid_r || outTake);
  assign pop       = rdDo || fetch;

  assign total     = memCnt_r + CNT_W'(outValid_r);
  assign depthMax  = mode_r ? DEPTH_FALL : DEPTH_STD;
  assign aeThresh  = CNT_W'(aeOfs_r) + CNT_W'(mode_r);
  assign afThresh  = depthMax - CNT_W'(afOfs_r);

  always_comb begin
    if (retxStart) begin
      memCnt_nxt = CNT_W'(wrPtr_r) + CNT_W'(wrDo);
    end else begin
      memCnt_nxt = memCnt_r + CNT_W'(wrDo) - CNT_W'(pop);
    end
  end

  // ---------------------------------------------------------------
  // Mode strap and memory
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_r <= link.fallThroughMode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrDo) begin
      mem[wrPtr_r] <= link.dataIn;
    end
  end

  // ---------------------------------------------------------------
  // Pointers and occupancy
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_r <= '0;
    end else if (wrDo) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdPtr_r <= '0;
    end else if (retxStart) begin
      rdPtr_r <= '0;
    end else if (pop) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      memCnt_r <= '0;
    end else begin
      memCnt_r <= memCnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Retransmit setup timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      retxCnt_r <= '0;
    end else if (retxStart) begin
      retxCnt_r <= RETX_LOAD;
    end else if (busy) begin
      retxCnt_r <= retxCnt_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------
  // Availability is one stage behind the count, giving the two-cycle
  // first-word latency; costs a cycle but keeps memory reads clean
  always_ff @(posedge core_clk) begin
    if (reset) begin
      memAvail_r <= 1'b0;
    end else begin
      memAvail_r <= !busy && (memCnt_r != '0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      outValid_r <= 1'b0;
    end else if (retxStart) begin
      outValid_r <= 1'b0;
    end else if (fetch) begin
      outValid_r <= 1'b1;
    end else if (outTake) begin
      outValid_r <= 1'b0;
    end
  end

  // Last word stays on the outputs after the final read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dataOut_r <= '0;
    end else if (pop) begin
      dataOut_r <= mem[rdPtr_r];
    end
  end

  // ---------------------------------------------------------------
  // Status flags, all taken from registered state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      emptyFlagN_r <= 1'b0;
    end else begin
      emptyFlagN_r <= !mode_r && !busy && (memCnt_r != '0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fullFlagN_r <= 1'b1;
    end else begin
      fullFlagN_r <= mode_r || (total != DEPTH_STD);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      inputReadyN_r <= 1'b1;
    end else begin
      inputReadyN_r <= !mode_r || (total == DEPTH_FALL);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      almostEmptyN_r <= 1'b0;
    end else begin
      almostEmptyN_r <= (total > aeThresh);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      almostFullN_r <= 1'b1;
    end else begin
      almostFullN_r <= (total < afThresh);
    end
  end

  // ---------------------------------------------------------------
  // Serial offset loading, empty offset first, LSB first
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loadCnt_r <= '0;
    end else if (link.offsetLoadSelectN) begin
      loadCnt_r <= '0;
    end else if (!link.serialEnN) begin
      loadCnt_r <= (loadCnt_r == LOAD_BITS - 1'b1) ? '0 : loadCnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aeOfs_r <= link.offsetLoadSelectN ? OFS_DEF_HI : OFS_DEF_LO;
      afOfs_r <= link.offsetLoadSelectN ? OFS_DEF_HI : OFS_DEF_LO;
    end else if (!link.offsetLoadSelectN && !link.serialEnN) begin
      if (loadCnt_r < LDC_W'(OFS_W)) begin
        aeOfs_r <= {link.serialIn, aeOfs_r[OFS_MSB:1]};
      end else begin
        afOfs_r <= {link.serialIn, afOfs_r[OFS_MSB:1]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Link outputs
  // ---------------------------------------------------------------
  assign link.dataOut          = dataOut_r;
  assign link.emptyFlagN       = emptyFlagN_r;
  assign link.fullFlagN        = fullFlagN_r;
  assign link.outputReadyN     = !(mode_r && outValid_r);
  assign link.inputReadyN      = inputReadyN_r;
  assign link.almostEmptyFlagN = almostEmptyN_r;
  assign link.almostFullFlagN  = almostFullN_r;

endmodule
`default_nettype wire

// ===== src/fifo_peer.sv
// Writing and reading party that drives the FIFO link
`timescale 1ns/10ps
`default_nettype none
module fifo_peer
  import fifo_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  fifo_link_if.peer              link,
  input  wire logic              fallThrough,
  input  wire logic              wrValid,
  input  wire logic [DATA_W-1:0] wrData,
  output logic                   wrReady,
  input  wire logic              rdReady,
  output logic                   rdValid,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              retxReq,
  output logic                   retxBusy,
  input  wire logic              loadReq,
  input  wire logic [OFS_W-1:0]  loadEmptyOfs,
  input  wire logic [OFS_W-1:0]  loadFullOfs,
  output logic                   loadBusy
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic                  stdRdValid_r;
  logic [CNT_W-1:0]      writes_r;
  logic                  retxWait_r;
  logic                  retxSeen_r;
  logic [2*OFS_W-1:0]    loadShift_r;
  logic [LDC_W-1:0]      loadCnt_r;
  logic                  loadActive_r;
  logic                  readyAll;
  logic                  validAll;
  logic                  wrDo;
  logic                  rdDo;
  logic                  retxGo;
  logic [CNT_W-1:0]      wrLimit;

  // Composite flags through gates; one device here, wider builds
  // extend these terms; the gates are combinational and absorb no skew
  assign readyAll = fallThrough ? !(link.inputReadyN)
                                : link.fullFlagN;
  assign validAll = fallThrough ? !(link.outputReadyN)
                                : link.emptyFlagN;

  // Writes stop at the limit so a retransmit stays possible
  assign wrLimit = fallThrough ? WR_LIMIT_FALL : WR_LIMIT_STD;
  assign wrReady = readyAll && (writes_r < wrLimit);
  assign wrDo    = wrValid && wrReady;

  assign rdDo    = rdReady && validAll && !retxWait_r;
  assign retxGo  = retxReq && !retxWait_r;

  // ---------------------------------------------------------------
  // Link drive
  // ---------------------------------------------------------------
  assign link.fallThroughMode   = fallThrough;
  assign link.writeEnN          = !wrDo;
  assign link.dataIn            = wrData;
  assign link.readEnN           = !rdDo;
  assign link.retransmitN       = !retxGo;
  assign link.offsetLoadSelectN = !loadActive_r;
  assign link.serialEnN         = !loadActive_r;
  assign link.serialIn          = loadShift_r[0];

  // Standard mode data arrives the cycle after the read strobe
  assign rdValid  = fallThrough ? (validAll && !retxWait_r) : stdRdValid_r;
  assign rdData   = link.dataOut;
  assign retxBusy = retxWait_r;
  assign loadBusy = loadActive_r;

  // ---------------------------------------------------------------
  // Read tracking and write budget
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stdRdValid_r <= 1'b0;
    end else begin
      stdRdValid_r <= !fallThrough && rdDo;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      writes_r <= '0;
    end else if (wrDo) begin
      writes_r <= writes_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Retransmit wait: flag must leave then return to ready
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      retxWait_r <= 1'b0;
      retxSeen_r <= 1'b0;
    end else if (retxGo) begin
      retxWait_r <= 1'b1;
      retxSeen_r <= 1'b0;
    end else if (retxWait_r) begin
      if (!validAll) begin
        retxSeen_r <= 1'b1;
      end else if (retxSeen_r) begin
        retxWait_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial offset load, empty offset then full offset, LSB first
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loadActive_r <= 1'b0;
      loadCnt_r    <= '0;
      loadShift_r  <= '0;
    end else if (!loadActive_r && loadReq) begin
      loadActive_r <= 1'b1;
      loadCnt_r    <= '0;
      loadShift_r  <= {loadFullOfs, loadEmptyOfs};
    end else if (loadActive_r) begin
      loadShift_r <= {1'b0, loadShift_r[2*OFS_W-1:1]};
      loadCnt_r   <= loadCnt_r + 1'b1;
      if (loadCnt_r == LOAD_BITS - 1'b1) begin
        loadActive_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/fifo_link_chk.sv
// Assertions on the link between the FIFO device and its peer
`timescale 1ns/10ps
`default_nettype none
module fifo_link_chk
  import fifo_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic writeEnN,
  input wire logic readEnN,
  input wire logic retransmitN,
  input wire logic fallThroughMode,
  input wire logic offsetLoadSelectN,
  input wire logic serialEnN,
  input wire logic emptyFlagN,
  input wire logic fullFlagN,
  input wire logic outputReadyN,
  input wire logic inputReadyN,
  input wire logic almostEmptyFlagN,
  input wire logic almostFullFlagN
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic             wrTake;
  logic             rdTake;
  logic [CNT_W-1:0] wrCnt_r;
  logic [CNT_W-1:0] occ_r;
  logic [4:0]       retxAge_r;
  logic [5:0]       shiftCnt_r;

  assign wrTake = !writeEnN && (fallThroughMode ? !inputReadyN : fullFlagN);
  assign rdTake = !readEnN && (fallThroughMode ? !outputReadyN : emptyFlagN);

  always_ff @(posedge core_clk) begin
    if (reset) wrCnt_r <= '0;
    else wrCnt_r <= wrCnt_r + CNT_W'(wrTake);
  end
  // Retransmit refills the buffer with every word since reset
  always_ff @(posedge core_clk) begin
    if (reset) occ_r <= '0;
    else if (!retransmitN) occ_r <= wrCnt_r + CNT_W'(wrTake);
    else occ_r <= occ_r + CNT_W'(wrTake) - CNT_W'(rdTake);
  end
  always_ff @(posedge core_clk) begin
    if (reset) retxAge_r <= 5'h1F;
    else if (!retransmitN) retxAge_r <= 5'h00;
    else if (retxAge_r != 5'h1F) retxAge_r <= retxAge_r + 5'h01;
  end
  always_ff @(posedge core_clk) begin
    if (reset || offsetLoadSelectN) shiftCnt_r <= 6'h00;
    else if (!serialEnN) shiftCnt_r <= shiftCnt_r + 6'h01;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence stdSetup;
    ##2 !emptyFlagN ##11 !emptyFlagN ##1 emptyFlagN;
  endsequence
  sequence ftSetup;
    ##1 outputReadyN ##13 outputReadyN ##1 !outputReadyN;
  endsequence

  AST_READY_RESET: assert property (
    $fell(reset) && fallThroughMode |-> ##1 !inputReadyN)
    else $error("input ready late after reset");
  AST_OR_FIRST: assert property (
    fallThroughMode && occ_r == '0 && wrTake
      |-> ##2 outputReadyN ##1 !outputReadyN)
    else $error("output ready latency wrong");
  AST_AE_RISE: assert property (
    $rose(almostEmptyFlagN) && retxAge_r > 5'h14 |-> $past(wrTake, 2))
    else $error("almost empty rose without write");
  AST_AF_RISE: assert property (
    $rose(almostFullFlagN) |-> $past(rdTake, 2))
    else $error("almost full rose without read");
  AST_AF_FALL: assert property (
    $fell(almostFullFlagN) && retxAge_r > 5'h14 |-> $past(wrTake, 2))
    else $error("almost full fell without write");
  AST_RETX_STD: assert property (
    !retransmitN && !fallThroughMode && retxAge_r > 5'h0E
      && wrCnt_r != '0 |-> stdSetup)
    else $error("standard retransmit timing wrong");
  AST_RETX_FT: assert property (
    !retransmitN && fallThroughMode && retxAge_r > 5'h0E
      && wrCnt_r != '0 |-> ftSetup)
    else $error("fall-through retransmit timing wrong");
  AST_ROOM_SETUP: assert property (
    retxAge_r < 5'h0E |-> (fallThroughMode ? !inputReadyN : fullFlagN))
    else $error("no room during retransmit setup");
  AST_SHIFT_COUNT: assert property (
    $rose(offsetLoadSelectN) && shiftCnt_r != 6'h00
      |-> shiftCnt_r == 6'(LOAD_BITS))
    else $error("serial offset load length wrong");
endmodule
`default_nettype wire

// ===== tb/dual_clock_fifo_flag_retransmit_bench.sv
// Self-checking bench for the FIFO device and its peer
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_flag_retransmit_bench;
  import fifo_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam time DLY     = 1ns;
  localparam int  CEILING = 90000;
  logic              core_clk = 1'h0;
  logic              reset = 1'h1;
  logic              fallThrough = 1'h0;
  logic              wrValid = 1'h0;
  logic [DATA_W-1:0] wrData = '0;
  logic              wrReady;
  logic              rdReady = 1'h0;
  logic              rdValid;
  logic [DATA_W-1:0] rdData;
  logic              retxReq = 1'h0;
  logic              retxBusy;
  logic              loadReq = 1'h0;
  logic [OFS_W-1:0]  loadEmptyOfs = '0;
  logic [OFS_W-1:0]  loadFullOfs = '0;
  logic              loadBusy;
  int                miscompares = 0;
  int                numChecks = 0;
  int                cycles = 0;

  always #2.5 core_clk = ~core_clk;

  fifo_link_if link();
  fifo_device fifo_device_inst (.core_clk(core_clk), .reset(reset),
    .link(link));
  fifo_peer fifo_peer_inst (.core_clk(core_clk), .reset(reset),
    .link(link), .fallThrough(fallThrough), .wrValid(wrValid),
    .wrData(wrData), .wrReady(wrReady), .rdReady(rdReady),
    .rdValid(rdValid), .rdData(rdData), .retxReq(retxReq),
    .retxBusy(retxBusy), .loadReq(loadReq), .loadEmptyOfs(loadEmptyOfs),
    .loadFullOfs(loadFullOfs), .loadBusy(loadBusy));
  fifo_link_chk fifo_link_chk_inst (.core_clk(core_clk), .reset(reset),
    .writeEnN(link.writeEnN), .readEnN(link.readEnN),
    .retransmitN(link.retransmitN), .fallThroughMode(link.fallThroughMode),
    .offsetLoadSelectN(link.offsetLoadSelectN), .serialEnN(link.serialEnN),
    .emptyFlagN(link.emptyFlagN), .fullFlagN(link.fullFlagN),
    .outputReadyN(link.outputReadyN), .inputReadyN(link.inputReadyN),
    .almostEmptyFlagN(link.almostEmptyFlagN),
    .almostFullFlagN(link.almostFullFlagN));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_of_test;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == CEILING) begin
      miscompares++;
      end_of_test();
    end
  end

  task check(input string what, input logic [DATA_W-1:0] exp,
             input logic [DATA_W-1:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs always move one fixed delay after the edge
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #DLY;
  endtask

  function automatic logic [DATA_W-1:0] ready();
    return {17'h0, fallThrough ? !link.outputReadyN : link.emptyFlagN};
  endfunction

  task doReset(input logic ft);
    fallThrough = ft;
    reset = 1'h1;
    tick(5);
    reset = 1'h0;
    tick(1);
    check("reset flags", 18'h0000B, {14'h0, link.outputReadyN,
      link.almostEmptyFlagN, link.almostFullFlagN, link.fullFlagN});
    check("reset data", 18'h00000, link.dataOut);
  endtask

  task load(input logic [OFS_W-1:0] n, input logic [OFS_W-1:0] m);
    loadEmptyOfs = n;
    loadFullOfs = m;
    loadReq = 1'h1;
    tick(1);
    loadReq = 1'h0;
    for (int k = 0; k < 80 && loadBusy; k++) @(negedge core_clk);
    tick(1);
  endtask

  task writeWord(input logic [DATA_W-1:0] d);
    wrData = d;
    wrValid = 1'h1;
    for (int k = 0; k < 50; k++) begin
      @(negedge core_clk);
      if (wrReady) break;
    end
    tick(1);
    wrValid = 1'h0;
  endtask

  task readCheck(input logic [DATA_W-1:0] exp);
    if (fallThrough) begin
      for (int k = 0; k < 50 && !rdValid; k++) @(negedge core_clk);
      check("read data", exp, rdData);
      tick(1);
      rdReady = 1'h1;
      tick(1);
      rdReady = 1'h0;
    end else begin
      rdReady = 1'h1;
      tick(1);
      rdReady = 1'h0;
      for (int k = 0; k < 50 && !rdValid; k++) @(negedge core_clk);
      check("read data", exp, rdData);
    end
    tick(1);
  endtask

  task retx;
    retxReq = 1'h1;
    tick(1);
    retxReq = 1'h0;
    tick(2);
    for (int k = 0; k < 80 && retxBusy; k++) @(negedge core_clk);
    check("setup done", 18'h00001, ready());
    tick(1);
  endtask

  // Streams until the peer stops taking words
  task fill(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    wrValid = 1'h1;
    for (int k = 0; k < 40000; k++) begin
      @(negedge core_clk);
      if (!wrReady) break;
      tick(1);
      n++;
      wrData = DATA_W'(n + 16);
    end
    tick(1);
    wrValid = 1'h0;
    check("write count", exp, DATA_W'(n));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run(input logic ft);
    int dm;
    int aeLim;
    logic [DATA_W-1:0] lim;
    dm = ft ? 4 : 3;
    aeLim = ft ? 2 : 1;
    lim = ft ? DATA_W'(WR_LIMIT_FALL) : DATA_W'(WR_LIMIT_STD);
    doReset(ft);
    load(15'h0001, 15'h7FFD);
    for (int i = 1; i <= 4; i++) begin
      writeWord(DATA_W'(i));
      if (i == 1) begin
        if (ft) tick(1);
        check("ready early", 18'h00000, ready());
        tick(1);
        check("ready", 18'h00001, ready());
        if (ft) check("first word", 18'h00001, link.dataOut);
      end
      tick(3);
      check("almost full", DATA_W'(i < dm),
        {17'h0, link.almostFullFlagN});
      check("almost empty", DATA_W'(i > aeLim),
        {17'h0, link.almostEmptyFlagN});
    end
    readCheck(18'h00001);
    readCheck(18'h00002);
    tick(3);
    check("almost full", 18'h00001, {17'h0, link.almostFullFlagN});
    check("almost empty", DATA_W'(2 > aeLim),
      {17'h0, link.almostEmptyFlagN});
    retx();
    readCheck(18'h00001);
    readCheck(18'h00002);
    fill(lim - 18'h00004);
    check("room", 18'h00001,
      {17'h0, ft ? !link.inputReadyN : link.fullFlagN});
    check("almost full", 18'h00000, {17'h0, link.almostFullFlagN});
    retx();
    readCheck(18'h00001);
  endtask

  initial begin
    run(1'h0);
    run(1'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
